// [core/urga_consts.svh]
`ifndef URGA_CONSTS_SVH
`define URGA_CONSTS_SVH

// ****************************************************************
// Register selectors on the configuration write/read port
// ****************************************************************
`define URGA_REG_MODE       3'h0
`define URGA_REG_BASE       3'h1
`define URGA_REG_SPAN       3'h2
`define URGA_REG_SEED       3'h3
`define URGA_REG_CFG_DONE   3'h4
`define URGA_REG_PRNG_STATE 3'h5

// ****************************************************************
// Field positions inside the per-link mode register
// ****************************************************************
`define URGA_MODE_RAND_BIT  0
`define URGA_MODE_LEN_BIT   1
`define URGA_MODE_JOIN_BIT  2

// ****************************************************************
// Reset values and masks
// ****************************************************************
`define URGA_RST_WORD       16'h0000
`define URGA_ONE_BYTE_MASK  16'h00ff
`define URGA_TWO_BYTE_MASK  16'hffff

`endif

// [core/urga_pkg.sv]
package urga_pkg;

	// Per-link packet processor states
	typedef enum logic [1:0] {
		URGA_IDLE = 2'b00,  // Waiting for a header from the link
		URGA_LOOK = 2'b01,  // Header presented to the interval selector
		URGA_WAIT = 2'b10   // Stalled for an output of the group
	} urga_state_e;

	typedef logic [15:0] urga_word_t;

endpackage

// [core/urga_router.sv]
`timescale 1ns/1ps
`include "urga_consts.svh"
// Function
// - randomize set routes on generated header
// - per-link 16-bit base and span registers
// - header lies in base to base+span-1; one-byte length keeps only its low byte
// - per-link seed starts the pseudo-random sequence
// - no random headers before config done
// - portal interval header is discarded, next exposed
// - generated header hitting portal dropped at once
// - no portal flag means no stripping
// - portal stripping happens on input side
// - join bit zero starts group, one continues
// - all join bits zero means no grouping
// - groups formed only after config done
// - group head request uses first free link not yet used this round
// - exactly one output takes each request
// - each group link sends once per round
// - excess inputs stall, freed link granted
// - stalled inputs served once per round
// - thirty-two links each own packet logic
// - length zero one byte, one two bytes
// - random header prefixed then interval-selected
module urga_router #(
	parameter int N_LINKS = 32
) (
	input  wire logic                 clk,
	input  wire logic                 rst_n,
	input  wire logic                 link_clk,
	input  wire logic [N_LINKS-1:0]   link_hdr_valid,
	input  wire logic [15:0]          link_hdr [N_LINKS],
	output logic      [N_LINKS-1:0]   link_hdr_ready,
	input  wire logic                 cfg_wr_en,
	input  wire logic [4:0]           cfg_link,
	input  wire logic [2:0]           cfg_addr,
	input  wire logic [15:0]          cfg_wdata,
	output logic      [15:0]          cfg_rdata,
	output logic      [15:0]          sel_hdr [N_LINKS],
	input  wire logic [N_LINKS-1:0]   sel_portal,
	input  wire logic [4:0]           sel_port [N_LINKS],
	input  wire logic [N_LINKS-1:0]   out_active,
	input  wire logic [N_LINKS-1:0]   out_done,
	output logic      [N_LINKS-1:0]   route_valid,
	output logic      [4:0]           route_out_link [N_LINKS],
	output logic      [15:0]          route_hdr [N_LINKS],
	output logic      [N_LINKS-1:0]   route_hdr_two,
	output logic      [N_LINKS-1:0]   route_rand_prefix
);

	// ****************************************************************
	// Configuration registers
	// ****************************************************************
	logic [N_LINKS-1:0] mode_rand;                 // Randomize per input link
	logic [N_LINKS-1:0] mode_len;                  // header_byte_count_sel
	logic [N_LINKS-1:0] mode_join;                 // group_join_bit as written
	logic [N_LINKS-1:0] join_q;                    // Join bits captured at config done
	urga_pkg::urga_word_t random_header_base [N_LINKS];
	urga_pkg::urga_word_t random_header_span [N_LINKS];
	urga_pkg::urga_word_t prng_start_value [N_LINKS];
	urga_pkg::urga_word_t lfsr_q [N_LINKS];        // Live generator state
	logic               cfg_done;                  // config_done_trigger seen
	logic               done_wr;                   // Write strobe to the trigger

	// ****************************************************************
	// Arbitration signals shared by all links
	// ****************************************************************
	logic [N_LINKS-1:0] waiting;                   // Input stalled on a group
	logic [4:0]         want_port [N_LINKS];       // Selected output of each input
	logic [N_LINKS-1:0] grant_in;                  // Input granted this cycle
	logic [4:0]         grant_link [N_LINKS];      // Output given to that input
	logic [N_LINKS-1:0] grant_out;                 // Outputs claimed this cycle
	logic [N_LINKS-1:0] claimed;                   // Outputs carrying a packet
	logic [4:0]         head [N_LINKS];            // Group head of each output
	logic [N_LINKS-1:0] used [N_LINKS];            // Outputs used this round per group
	logic [N_LINKS-1:0] served [N_LINKS];          // Inputs served this round per group
	logic [N_LINKS-1:0] next_used [N_LINKS];
	logic [N_LINKS-1:0] next_served [N_LINKS];

	// Link-domain reset, brought across by two flops
	logic lrst_s1;
	logic lrst_n;

	assign done_wr = cfg_wr_en && (cfg_addr == `URGA_REG_CFG_DONE);

	// Lowest set bit of a mask, with a found flag on top
	function automatic logic [5:0] first_one(input logic [N_LINKS-1:0] m);
		logic [5:0] r;
		r = 6'h00;
		for (int k = N_LINKS - 1; k >= 0; k--) begin
			if (m[k]) begin
				r = {1'b1, k[4:0]};
			end
		end
		return r;
	endfunction

	// ****************************************************************
	// Register writes
	// ****************************************************************
	// Per-link settings; software must program before the trigger
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			mode_rand <= '0;
			mode_len  <= '0;
			mode_join <= '0;
			for (int k = 0; k < N_LINKS; k++) begin
				random_header_base[k] <= `URGA_RST_WORD;
				random_header_span[k] <= `URGA_RST_WORD;
				prng_start_value[k]   <= `URGA_RST_WORD;
			end
		end else if (cfg_wr_en) begin
			case (cfg_addr)
				`URGA_REG_MODE: begin
					mode_rand[cfg_link] <= cfg_wdata[`URGA_MODE_RAND_BIT];
					mode_len[cfg_link]  <= cfg_wdata[`URGA_MODE_LEN_BIT];
					mode_join[cfg_link] <= cfg_wdata[`URGA_MODE_JOIN_BIT];
				end
				`URGA_REG_BASE: random_header_base[cfg_link] <= cfg_wdata;
				`URGA_REG_SPAN: random_header_span[cfg_link] <= cfg_wdata;
				`URGA_REG_SEED: prng_start_value[cfg_link] <= cfg_wdata;
				default: begin
					// Trigger and read-only selectors store nothing here
				end
			endcase
		end
	end

	// Trigger: arms generators and freezes the group map
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_done <= 1'b0;
			join_q   <= '0;
		end else if (done_wr) begin
			cfg_done <= 1'b1;
			join_q   <= mode_join;
		end
	end

	// Read port: one cycle of latency, unknown selectors read zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_rdata <= `URGA_RST_WORD;
		end else begin
			case (cfg_addr)
				`URGA_REG_MODE:       cfg_rdata <= {13'h0000, mode_join[cfg_link],
					mode_len[cfg_link], mode_rand[cfg_link]};
				`URGA_REG_BASE:       cfg_rdata <= random_header_base[cfg_link];
				`URGA_REG_SPAN:       cfg_rdata <= random_header_span[cfg_link];
				`URGA_REG_SEED:       cfg_rdata <= prng_start_value[cfg_link];
				`URGA_REG_CFG_DONE:   cfg_rdata <= {15'h0000, cfg_done};
				`URGA_REG_PRNG_STATE: cfg_rdata <= lfsr_q[cfg_link];
				default:              cfg_rdata <= `URGA_RST_WORD;
			endcase
		end
	end

	// ****************************************************************
	// Group map and arbitration
	// ****************************************************************
	// Each output points at the head of its group; before the trigger
	// every output is its own head
	always_comb begin
		for (int j = 0; j < N_LINKS; j++) begin
			if (j == 0 || !cfg_done || !join_q[j]) begin
				head[j] = j[4:0];
			end else begin
				head[j] = head[j-1];
			end
		end
	end

	// One grant per group per cycle; round masks give the fairness.
	// Stalling an idle-but-used output trades throughput for strict turns.
	always_comb begin
		logic [N_LINKS-1:0] wmask;
		logic [N_LINKS-1:0] mmask;
		logic [N_LINKS-1:0] ei;
		logic [N_LINKS-1:0] eo;
		logic [5:0]         pi;
		logic [5:0]         po;
		logic               fresh;
		wmask     = '0;
		mmask     = '0;
		ei        = '0;
		eo        = '0;
		pi        = 6'h00;
		po        = 6'h00;
		fresh     = 1'b0;
		grant_in  = '0;
		grant_out = '0;
		for (int k = 0; k < N_LINKS; k++) begin
			grant_link[k] = 5'h00;
		end
		for (int g = 0; g < N_LINKS; g++) begin
			for (int k = 0; k < N_LINKS; k++) begin
				wmask[k] = waiting[k] && (head[want_port[k]] == g[4:0]);
				mmask[k] = out_active[k] && (head[k] == g[4:0]);
			end
			eo    = mmask & ~claimed & ~used[g];
			ei    = wmask & ~served[g];
			fresh = (ei == '0);
			if (fresh) begin
				ei = wmask;
			end
			pi = first_one(ei);
			po = first_one(eo);
			next_used[g]   = used[g];
			next_served[g] = served[g];
			if (pi[5] && po[5]) begin
				grant_in[pi[4:0]]   = 1'b1;
				grant_link[pi[4:0]] = po[4:0];
				grant_out[po[4:0]]  = 1'b1;
				next_used[g][po[4:0]] = 1'b1;
				if (fresh) begin
					next_served[g] = '0;
				end
				next_served[g][pi[4:0]] = 1'b1;
			end
			// Round ends once every active member has sent
			if ((next_used[g] & mmask) == mmask) begin
				next_used[g] = '0;
			end
		end
	end

	// Round masks per group
	always_ff @(posedge clk) begin
		if (!rst_n || done_wr) begin
			for (int g = 0; g < N_LINKS; g++) begin
				used[g]   <= '0;
				served[g] <= '0;
			end
		end else begin
			for (int g = 0; g < N_LINKS; g++) begin
				used[g]   <= next_used[g];
				served[g] <= next_served[g];
			end
		end
	end

	// Output claim: a grant in the release cycle keeps the output held
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			claimed <= '0;
		end else begin
			claimed <= (claimed & ~out_done) | grant_out;
		end
	end

	// ****************************************************************
	// Link-domain reset synchroniser
	// ****************************************************************
	always_ff @(posedge link_clk) begin
		lrst_s1 <= rst_n;
		lrst_n  <= lrst_s1;
	end

	// ****************************************************************
	// Per-link packet processors
	// ****************************************************************
	for (genvar i = 0; i < N_LINKS; i++) begin : g_link
		logic                 busy_l;      // Header held, waiting on core
		logic                 req_tgl_l;   // Request toggle, link side
		urga_pkg::urga_word_t hdr_hold_l;  // Header stable while busy
		logic                 ack_s1;
		logic                 ack_s2;
		logic                 ack_s3;
		logic                 req_s1;
		logic                 req_s2;
		logic                 req_s3;
		logic                 ack_tgl;     // Acknowledge toggle, core side
		logic                 new_req;
		logic                 rand_on;
		logic                 is_rand;     // Presented header is generated
		urga_pkg::urga_word_t orig_hdr;
		urga_pkg::urga_word_t hmask;
		urga_pkg::urga_word_t rnd;
		urga_pkg::urga_word_t lfsr_step;
		urga_pkg::urga_state_e st;

		// Link side: take a header, hold it, raise the request toggle
		always_ff @(posedge link_clk) begin
			if (!lrst_n) begin
				busy_l     <= 1'b0;
				req_tgl_l  <= 1'b0;
				hdr_hold_l <= `URGA_RST_WORD;
			end else if (!busy_l && link_hdr_valid[i]) begin
				busy_l     <= 1'b1;
				req_tgl_l  <= ~req_tgl_l;
				hdr_hold_l <= link_hdr[i];
			end else if (ack_s2 ^ ack_s3) begin
				busy_l <= 1'b0;
			end
		end

		// Acknowledge crossing into the link domain
		always_ff @(posedge link_clk) begin
			if (!lrst_n) begin
				ack_s1 <= 1'b0;
				ack_s2 <= 1'b0;
				ack_s3 <= 1'b0;
			end else begin
				ack_s1 <= ack_tgl;
				ack_s2 <= ack_s1;
				ack_s3 <= ack_s2;
			end
		end

		assign link_hdr_ready[i] = lrst_n && !busy_l;

		// Request crossing into the core domain
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				req_s1 <= 1'b0;
				req_s2 <= 1'b0;
				req_s3 <= 1'b0;
			end else begin
				req_s1 <= req_tgl_l;
				req_s2 <= req_s1;
				req_s3 <= req_s2;
			end
		end

		assign new_req   = (req_s2 ^ req_s3) && (st == urga_pkg::URGA_IDLE);
		assign rand_on   = mode_rand[i] && cfg_done;
		assign hmask     = mode_len[i] ? `URGA_TWO_BYTE_MASK : `URGA_ONE_BYTE_MASK;
		assign lfsr_step = {lfsr_q[i][14:0],
			lfsr_q[i][15] ^ lfsr_q[i][13] ^ lfsr_q[i][12] ^ lfsr_q[i][10]};
		// Zero span has no legal value; base is used alone
		assign rnd = (random_header_base[i] + ((random_header_span[i] == `URGA_RST_WORD) ?
			`URGA_RST_WORD : (lfsr_q[i] % random_header_span[i]))) & hmask;

		// Generator: seeded at the trigger, stepped once per packet while randomizing is on
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				lfsr_q[i] <= `URGA_RST_WORD;
			end else if (done_wr) begin
				lfsr_q[i] <= prng_start_value[i];
			end else if (new_req && rand_on) begin
				lfsr_q[i] <= lfsr_step;
			end
		end

		// Header processing state machine, input side
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				st                   <= urga_pkg::URGA_IDLE;
				is_rand              <= 1'b0;
				orig_hdr             <= `URGA_RST_WORD;
				sel_hdr[i]           <= `URGA_RST_WORD;
				want_port[i]         <= 5'h00;
				ack_tgl              <= 1'b0;
				route_valid[i]       <= 1'b0;
				route_out_link[i]    <= 5'h00;
				route_hdr[i]         <= `URGA_RST_WORD;
				route_hdr_two[i]     <= 1'b0;
				route_rand_prefix[i] <= 1'b0;
			end else begin
				route_valid[i] <= 1'b0;
				case (st)
					urga_pkg::URGA_IDLE: begin
						if (new_req) begin
							// Held header is stable: the toggle followed it
							orig_hdr <= hdr_hold_l & hmask;
							st       <= urga_pkg::URGA_LOOK;
							if (rand_on) begin
								sel_hdr[i] <= rnd;
								is_rand    <= 1'b1;
							end else begin
								sel_hdr[i] <= hdr_hold_l & hmask;
								is_rand    <= 1'b0;
							end
						end
					end
					urga_pkg::URGA_LOOK: begin
						if (sel_portal[i] && is_rand) begin
							// Generated header landed here: drop, expose original
							sel_hdr[i] <= orig_hdr;
							is_rand    <= 1'b0;
						end else if (sel_portal[i]) begin
							// Strip header; next header from the link routes
							ack_tgl <= ~ack_tgl;
							st      <= urga_pkg::URGA_IDLE;
						end else begin
							// No portal hit: route as presented
							want_port[i] <= sel_port[i];
							st           <= urga_pkg::URGA_WAIT;
						end
					end
					urga_pkg::URGA_WAIT: begin
						if (grant_in[i]) begin
							route_valid[i]       <= 1'b1;
							route_out_link[i]    <= grant_link[i];
							route_hdr[i]         <= sel_hdr[i];
							route_hdr_two[i]     <= mode_len[i];
							route_rand_prefix[i] <= is_rand;
							ack_tgl              <= ~ack_tgl;
							st                   <= urga_pkg::URGA_IDLE;
						end
					end
					default: begin
						st <= urga_pkg::URGA_IDLE;
					end
				endcase
			end
		end

		assign waiting[i] = (st == urga_pkg::URGA_WAIT);
	end

endmodule

// [tb/urga_router_chk.sv]
`timescale 1ns/1ps
`include "urga_consts.svh"
module urga_router_chk #(
	parameter int N_LINKS = 32
) (
	input wire logic               clk,
	input wire logic               rst_n,
	input wire logic               link_clk,
	input wire logic [N_LINKS-1:0] link_hdr_valid,
	input wire logic [N_LINKS-1:0] link_hdr_ready,
	input wire logic               cfg_wr_en,
	input wire logic [4:0]         cfg_link,
	input wire logic [2:0]         cfg_addr,
	input wire logic [15:0]        cfg_wdata,
	input wire logic [15:0]        cfg_rdata,
	input wire logic [N_LINKS-1:0] out_active,
	input wire logic [N_LINKS-1:0] out_done,
	input wire logic [N_LINKS-1:0] route_valid,
	input wire logic [4:0]         route_out_link [N_LINKS],
	input wire logic [15:0]        route_hdr [N_LINKS],
	input wire logic [N_LINKS-1:0] route_hdr_two,
	input wire logic [N_LINKS-1:0] route_rand_prefix
);
	// ****
	// Shadow state
	// ****
	logic               done_seen;       // Trigger written since reset
	logic [15:0]        base_c [N_LINKS]; // Shadow of the base registers
	logic [15:0]        span_c [N_LINKS]; // Shadow of the span registers
	logic [N_LINKS-1:0] claimed;         // Outputs granted and not yet done
	logic [N_LINKS-1:0] act_d;           // Output activity seen at grant time
	logic               clash;
	logic               reuse;
	// Shadows reset to zero like the registers
	always_ff @(posedge clk) begin
		act_d <= out_active;
		if (!rst_n) begin
			done_seen <= 1'b0;
			for (int k = 0; k < N_LINKS; k++) begin
				base_c[k] <= 16'h0000;
				span_c[k] <= 16'h0000;
			end
		end else if (cfg_wr_en) begin
			if (cfg_addr == `URGA_REG_CFG_DONE) done_seen <= 1'b1;
			if (cfg_addr == `URGA_REG_BASE) base_c[cfg_link] <= cfg_wdata;
			if (cfg_addr == `URGA_REG_SPAN) span_c[cfg_link] <= cfg_wdata;
		end
	end
	// A grant seen later than a done wins, so claim set follows clear
	always_ff @(posedge clk) begin
		if (!rst_n) claimed <= '0;
		else for (int k = 0; k < N_LINKS; k++) begin
			if (out_done[k]) claimed[k] <= 1'b0;
			for (int i = 0; i < N_LINKS; i++)
				if (route_valid[i] && route_out_link[i] == k) claimed[k] <= 1'b1;
		end
	end
	// Two grants on one output, or a grant on a held output
	always_comb begin
		clash = 1'b0;
		reuse = 1'b0;
		for (int i = 0; i < N_LINKS; i++) if (route_valid[i]) begin
			if (claimed[route_out_link[i]]) reuse = 1'b1;
			for (int j = i + 1; j < N_LINKS; j++)
				if (route_valid[j] && route_out_link[j] == route_out_link[i]) clash = 1'b1;
		end
	end
	sequence s_base_write;
		cfg_wr_en && cfg_addr == `URGA_REG_BASE;
	endsequence
	sequence s_base_read;
		!cfg_wr_en && cfg_addr == `URGA_REG_BASE && cfg_link == $past(cfg_link);
	endsequence
	a_base_read_back: assert property (@(posedge clk) disable iff (!rst_n)
		s_base_write ##1 s_base_read |=> cfg_rdata == $past(cfg_wdata, 2))
		else $error("base read back differs");
	a_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
		cfg_addr[2:1] == 2'b11 |=> cfg_rdata == 16'h0000)
		else $error("unmapped selector read not zero");
	a_rand_after_done: assert property (@(posedge clk) disable iff (!rst_n)
		(route_valid & route_rand_prefix) != '0 |-> done_seen)
		else $error("random header before trigger");
	a_single_owner: assert property (@(posedge clk) disable iff (!rst_n) !clash)
		else $error("two inputs granted one output");
	a_claim_held: assert property (@(posedge clk) disable iff (!rst_n) !reuse)
		else $error("busy output granted again");
	for (genvar k = 0; k < N_LINKS; k++) begin : g_link
		a_one_byte_len: assert property (@(posedge clk) disable iff (!rst_n)
			route_valid[k] && !route_hdr_two[k] |-> route_hdr[k][15:8] == 8'h00)
			else $error("one byte header too wide");
		a_rand_in_span: assert property (@(posedge clk) disable iff (!rst_n)
			route_valid[k] && route_rand_prefix[k] && route_hdr_two[k] && span_c[k] != 0
			|-> 16'(route_hdr[k] - base_c[k]) < span_c[k])
			else $error("random header out of span");
		a_active_out: assert property (@(posedge clk) disable iff (!rst_n)
			route_valid[k] |-> act_d[route_out_link[k]])
			else $error("grant on inactive output");
		a_ready_drop: assert property (@(posedge link_clk) disable iff (!rst_n)
			link_hdr_valid[k] && link_hdr_ready[k] |=> !link_hdr_ready[k] [*2])
			else $error("ready not dropped after take");
	end
endmodule
bind urga_router urga_router_chk #(.N_LINKS(N_LINKS)) urga_router_chk_inst (
	.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .link_hdr_valid(link_hdr_valid),
	.link_hdr_ready(link_hdr_ready), .cfg_wr_en(cfg_wr_en), .cfg_link(cfg_link),
	.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
	.out_active(out_active), .out_done(out_done), .route_valid(route_valid),
	.route_out_link(route_out_link), .route_hdr(route_hdr), .route_hdr_two(route_hdr_two),
	.route_rand_prefix(route_rand_prefix));

// [tb/urga_peer.sv]
`timescale 1ns/1ps
module urga_peer #(
	parameter int N_LINKS = 32
) (
	input wire logic               link_clk,
	input wire logic [N_LINKS-1:0] link_hdr_ready,
	output logic     [N_LINKS-1:0] link_hdr_valid,
	output logic     [15:0]        link_hdr [N_LINKS],
	input wire logic [15:0]        sel_hdr [N_LINKS],
	output logic     [N_LINKS-1:0] sel_portal,
	output logic     [4:0]         sel_port [N_LINKS]
);
	// ****
	// Peer senders and interval table
	// ****
	logic        portal_en = 1'b0;  // Portal interval armed
	logic [15:0] portal_lo = 16'hf000;
	logic [15:0] portal_hi = 16'hf0ff;
	logic [4:0]  dest      = 5'h04;
	initial begin
		link_hdr_valid = '0;
		foreach (link_hdr[k]) link_hdr[k] = 16'h0000;
	end
	// Random range sits apart from destination headers
	always_comb for (int k = 0; k < N_LINKS; k++) begin
		sel_portal[k] = portal_en && sel_hdr[k] >= portal_lo && sel_hdr[k] <= portal_hi;
		sel_port[k] = dest;
	end
	// Offer held until a rising edge takes it; data scrambled once released
	task automatic send(input int k, input logic [15:0] h);
		@(negedge link_clk);
		link_hdr_valid[k] = 1'b1;
		link_hdr[k] = h;
		while (link_hdr_ready[k] !== 1'b1) @(negedge link_clk);
		@(negedge link_clk);
		link_hdr_valid[k] = 1'b0;
		link_hdr[k] = ~h;
	endtask
endmodule

// [tb/tb_top.sv]
`timescale 1ns/1ps
`include "urga_consts.svh"
module tb_top;
	// ****
	// Stimulus and model state
	// ****
	logic        clk = 1'b0;
	logic        rst_n = 1'b0;
	logic        link_clk = 1'b0;
	logic        cfg_wr_en = 1'b0;
	logic [4:0]  cfg_link = 5'h00;
	logic [2:0]  cfg_addr = 3'h0;
	logic [15:0] cfg_wdata = 16'h0000;
	logic [15:0] cfg_rdata;
	logic [31:0] out_active = '1;
	logic [31:0] out_done = '0;
	logic [31:0] link_hdr_valid, link_hdr_ready, sel_portal, route_valid;
	logic [31:0] route_hdr_two, route_rand_prefix;
	logic [15:0] link_hdr [32], sel_hdr [32], route_hdr [32];
	logic [4:0]  sel_port [32], route_out_link [32];
	int          miscompares = 0, check_count = 0, cycles = 0;
	int          busy [32] = '{default: 0};
	int          use_cnt [32];
	int          exp_q [32][$]; // Expected headers per input, -1 means range only
	always #12.5 clk = ~clk;
	initial #3 forever #7.5 link_clk = ~link_clk;
	urga_router urga_router_inst (.clk(clk), .rst_n(rst_n), .link_clk(link_clk),
		.link_hdr_valid(link_hdr_valid), .link_hdr(link_hdr), .link_hdr_ready(link_hdr_ready),
		.cfg_wr_en(cfg_wr_en), .cfg_link(cfg_link), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .sel_hdr(sel_hdr), .sel_portal(sel_portal), .sel_port(sel_port),
		.out_active(out_active), .out_done(out_done), .route_valid(route_valid),
		.route_out_link(route_out_link), .route_hdr(route_hdr), .route_hdr_two(route_hdr_two),
		.route_rand_prefix(route_rand_prefix));
	urga_peer urga_peer_inst (.link_clk(link_clk), .link_hdr_ready(link_hdr_ready),
		.link_hdr_valid(link_hdr_valid), .link_hdr(link_hdr), .sel_hdr(sel_hdr),
		.sel_portal(sel_portal), .sel_port(sel_port));
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(input int l, input logic [2:0] a, input int d);
		cfg_link = 5'(l);
		cfg_addr = a;
		cfg_wdata = 16'(d);
		cfg_wr_en = 1'b1;
		@(negedge clk);
		cfg_wr_en = 1'b0;
		@(negedge clk);
	endtask
	task automatic rd(input int l, input logic [2:0] a, input int e);
		cfg_link = 5'(l);
		cfg_addr = a;
		@(negedge clk);
		chk("cfg_rdata", 16'(e), cfg_rdata);
	endtask
	// Queue the expectation first, then hand the header over
	task automatic go(input int k, input logic [15:0] h, input int e);
		if (e != -3) exp_q[k].push_back(e);
		urga_peer_inst.send(k, h);
	endtask
	function automatic int pending();
		pending = 0;
		foreach (exp_q[k]) pending += exp_q[k].size() + (busy[k] > 0);
	endfunction
	task automatic drain();
		for (int t = 0; t < 800 && pending() > 0; t++) @(negedge clk);
		// A drain that runs out with work left counts as a mismatch
		if (pending() > 0) chk("pending", 16'h0000, 16'(pending()));
	endtask
	// Output side: each grant holds its output a few cycles, then done pulses
	always @(negedge clk) begin
		int e;
		cycles++;
		if (cycles > 20000) begin
			miscompares++;
			report_and_stop();
		end
		for (int k = 0; k < 32; k++) begin
			out_done[k] = (busy[k] == 1);
			if (busy[k] > 0) busy[k]--;
		end
		for (int k = 0; k < 32; k++) if (route_valid[k] === 1'b1) begin
			e = exp_q[k].size() ? exp_q[k].pop_front() : -2;
			if (e == -2) chk("route_valid", 16'h0000, 16'h0001);
			if (e >= 0) chk("route_hdr", 16'(e), route_hdr[k]);
			// Bit 16 of an expectation marks a generated prefix; -1 has it set too
			if (e != -2) chk("route_rand_prefix", 16'(e[16]), 16'(route_rand_prefix[k]));
			use_cnt[route_out_link[k]]++;
			busy[route_out_link[k]] = 4;
		end
	end
	initial begin
		int b, s, sd;
		void'($urandom(14));
		b = 16'h0100 + $urandom_range(255);
		s = 1 + $urandom_range(63);
		sd = 1 + $urandom_range(16'hfffd);
		repeat (10) @(negedge clk);
		rst_n = 1'b1;
		rd(3, `URGA_REG_MODE, 0);
		wr(9, `URGA_REG_BASE, b);
		rd(9, `URGA_REG_BASE, b);
		rd(9, 3'h6, 0);
		for (int k = 5; k < 8; k++) wr(k, `URGA_REG_MODE, 16'h0004);
		wr(9, `URGA_REG_MODE, 16'h0003);
		wr(12, `URGA_REG_MODE, 16'h0002);
		use_cnt = '{default: 0};
		go(0, 16'h0040, 16'h0040);
		go(1, 16'h0041, 16'h0041);
		go(9, 16'h0009, 16'h0009);
		go(12, 16'hf010, 16'hf010);
		drain();
		chk("use_cnt", 16'h0004, 16'(use_cnt[4]));
		// Seeds nonzero and distinct, all set before the trigger
		for (int k = 9; k < 11; k++) begin
			wr(k, `URGA_REG_BASE, b);
			wr(k, `URGA_REG_SPAN, s);
			wr(k, `URGA_REG_SEED, sd + k - 9);
		end
		wr(10, `URGA_REG_MODE, 16'h0001);
		wr(11, `URGA_REG_MODE, 16'h0003);
		wr(11, `URGA_REG_BASE, 16'hf000);
		wr(11, `URGA_REG_SPAN, 16'h0010);
		wr(11, `URGA_REG_SEED, 16'h0005);
		wr(0, `URGA_REG_CFG_DONE, 16'h0001);
		rd(0, `URGA_REG_CFG_DONE, 16'h0001);
		use_cnt = '{default: 0};
		for (int k = 0; k < 8; k++) fork
			automatic int j = k;
			go(j, 16'(j), j);
		join_none
		wait fork;
		drain();
		for (int k = 4; k < 8; k++) chk("use_cnt", 16'h0002, 16'(use_cnt[k]));
		// An output that is not active must never take a packet of its group
		use_cnt = '{default: 0};
		out_active[5] = 1'b0;
		go(0, 16'h0030, 16'h0030);
		go(0, 16'h0031, 16'h0031);
		drain();
		chk("use_cnt", 16'h0000, 16'(use_cnt[5]));
		chk("use_cnt", 16'h0001, 16'(use_cnt[6]));
		out_active[5] = 1'b1;
		go(9, 16'h0019, 32'h0001_0000 | ((b + sd % s) & 16'hffff));
		go(9, 16'h0029, -1);
		go(10, 16'h001a, 32'h0001_0000 | ((b + (sd + 1) % s) & 16'h00ff));
		urga_peer_inst.portal_en = 1'b1;
		go(11, 16'h0011, 16'h0011);
		go(12, 16'hf020, -3);
		go(12, 16'h0012, 16'h0012);
		drain();
		report_and_stop();
	end
endmodule
